/* hw/njd_pkg.sv */
// Package: register map, field layout and timing constants for the join/diagnostics block
package njd_pkg;

    // Bus and data widths
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned STN_W      = 8;
    localparam int unsigned RAM_ADDR_W = 11;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_STATION  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONFIG   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FIRST_SETUP_REGISTER   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PROBE    = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_NEXT_STN = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DIAG     = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_XSTAT    = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_CMD      = 8'h1c;

    // Configuration register fields
    localparam int unsigned CFG_JOIN_BIT = 5;

    // Setup register fields
    localparam int unsigned SU_SHORT_BIT = 0;
    localparam int unsigned SU_SEL1_BIT  = 1;
    localparam int unsigned SU_SEL2_BIT  = 2;
    localparam int unsigned SU_W         = 3;

    // Diagnostic status fields
    localparam int unsigned DG_SELF_BIT  = 7;
    localparam int unsigned DG_CLASH_BIT = 6;
    localparam int unsigned DG_LINE_BIT  = 5;
    localparam int unsigned DG_PASS_BIT  = 4;
    localparam int unsigned DG_SUCC_BIT  = 3;
    localparam int unsigned DG_PROBE_BIT = 2;
    localparam int unsigned DG_DONE_BIT  = 1;

    // Transmit status fields
    localparam int unsigned XS_FREE_BIT   = 0;
    localparam int unsigned XS_REFUSE_BIT = 1;

    // Command register fields
    localparam int unsigned CMD_DISABLE_BIT = 0;
    localparam int unsigned CMD_CLEAR_BIT   = 1;

    // Start-up buffer writes
    localparam logic [RAM_ADDR_W-1:0] RAM_ADDR_MARK = 11'h000;
    localparam logic [RAM_ADDR_W-1:0] RAM_ADDR_STN  = 11'h001;
    localparam logic [STN_W-1:0]      RAM_MARK_DATA = 8'hd1;

    // Refusal limits
    localparam int unsigned   REFUSE_CNT_W   = 7;
    localparam logic [6:0]    REFUSE_LONG_MAX  = 7'h7f;
    localparam logic [6:0]    REFUSE_SHORT_MAX = 7'h03;

    // Clash watch window
    localparam int unsigned CLK_FREQ_KHZ   = 100000;
    localparam int unsigned CLASH_WIN_MS   = 420;
    localparam int unsigned CLASH_LONG_MS  = 840;
    localparam int unsigned CLASH_WIN_CYC  = CLASH_WIN_MS * CLK_FREQ_KHZ;
    localparam int unsigned CLASH_LONG_CYC = CLASH_LONG_MS * CLK_FREQ_KHZ;
    localparam int unsigned WIN_CNT_W      = 27;

    // Reset values
    localparam logic [STN_W-1:0] STATION_RST = 8'h00;
    localparam logic [SU_W-1:0]  SETUP_RST   = 3'h0;

    // Network-side events seen by the block
    typedef struct packed {
        logic             token_seen;
        logic             token_own;
        logic [STN_W-1:0] token_dest;
        logic             token_answered;
        logic             token_for_us;
        logic             rx_timer_expired;
        logic             refusal;
        logic             buffer_ok;
        logic             successor_valid;
        logic [STN_W-1:0] successor_id;
    } njd_net_ev_t;

    // Buffer RAM write port
    typedef struct packed {
        logic                  we;
        logic [RAM_ADDR_W-1:0] addr;
        logic [STN_W-1:0]      data;
    } njd_ram_wr_t;

    // Control toward the protocol core
    typedef struct packed {
        logic core_run;
        logic may_join;
        logic rebuild_req;
    } njd_core_ctl_t;

endpackage

/* hw/njd_top.sv */
// Node join gating, clash and probe detection, and sticky diagnostic flags
//
// Overview of operation
// - Zero station number keeps core fully idle
// - Non-zero number wakes core; join waits
// - Clash flag within 420 ms, else 840
// - Clash: token destination answered equals ours
// - Diagnostic status read clears clash flag
// - Joining causes rebuild, sets self-rebuild flag
// - Probe value watched after every write
// - Probe answer sets probe-match flag
// - Successor readable from next-station register
// - Own receive timer expiry sets self-rebuild once joined
// - Diagnostic status read clears self-rebuild
// - Configuration bit 5 is join allow
// - Line activity flag on receive one
// - Pass-frame flag on foreign tokens only
// - Refusal limit 128 or 4, interrupt
// - Disable command frees sender on token
// - Refusal counter wraps; clear command rearms
// - Successor change flag on new successor
// - Non-zero station write stores d1 and number
`timescale 1ns/10ps

module njd_top
    import njd_pkg::*;
#(
    parameter int unsigned CLASH_WIN_CYCLES  = njd_pkg::CLASH_WIN_CYC,
    parameter int unsigned CLASH_LONG_CYCLES = njd_pkg::CLASH_LONG_CYC
) (
    // Clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_n_in,
    // APB slave
    input  wire logic                         psel_in,
    input  wire logic                         penable_in,
    input  wire logic                         pwrite_in,
    input  wire logic [njd_pkg::ADDR_W-1:0]   paddr_in,
    input  wire logic [njd_pkg::DATA_W-1:0]   pwdata_in,
    output logic      [njd_pkg::DATA_W-1:0]   prdata_out,
    output logic                              pready_out,
    output logic                              pslverr_out,
    // Network side
    input  wire logic                         serial_receive_input_in,
    input  wire njd_pkg::njd_net_ev_t         net_ev_in,
    // Core side
    output njd_pkg::njd_core_ctl_t            core_ctl_out,
    output njd_pkg::njd_ram_wr_t              ram_wr_out,
    output logic                              refusal_irq_out
);
    import njd_pkg::*;

    typedef enum logic [1:0] {
        NJD_RAM_IDLE,
        NJD_RAM_MARK,
        NJD_RAM_STN
    } njd_ram_st_t;

    // Address decode shared by read and write paths
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // Software-visible state
    logic [STN_W-1:0]        station_q;
    logic                    join_allow_bit_q;
    logic [SU_W-1:0]         setup_q;
    logic [STN_W-1:0]        probe_q;
    logic                    probe_armed_q;
    logic [STN_W-1:0]        next_stn_q;
    // Sticky flags
    logic                    self_caused_ring_rebuild_q;
    logic                    clash_detected_flag_q;
    logic                    line_activity_flag_q;
    logic                    pass_frame_seen_q;
    logic                    successor_changed_flag_q;
    logic                    probe_match_flag_q;
    logic                    clash_done_q;
    logic                    refusal_limit_flag_q;
    logic                    sender_free_flag_q;
    logic                    disable_pend_q;
    // Network tracking
    logic [STN_W-1:0]        last_dest_q;
    logic                    last_valid_q;
    logic [REFUSE_CNT_W-1:0] refuse_cnt_q;
    logic [WIN_CNT_W-1:0]    win_cnt_q;
    logic                    join_prev_q;
    njd_ram_st_t             ram_st_q;
    // Bus strobes and derived terms
    logic                    acc;
    logic                    wr_en;
    logic                    rd_en;
    logic                    mapped;
    logic                    diag_rd;
    logic                    stn_wr;
    logic                    cmd_wr;
    logic                    core_run;
    logic                    joined;
    logic                    join_evt;
    logic                    timer_evt;
    logic                    answered_dest_ok;
    logic                    clash_set;
    logic                    probe_set;
    logic                    refuse_max_hit;
    logic [REFUSE_CNT_W-1:0] refuse_max;
    logic [WIN_CNT_W-1:0]    win_limit;

    // Zero-wait slave: every access completes in its first access cycle
    assign acc     = psel_in & penable_in;
    assign wr_en   = acc & pwrite_in;
    assign rd_en   = acc & ~pwrite_in;
    assign mapped  = hit(paddr_in, OFS_STATION) | hit(paddr_in, OFS_CONFIG)
                   | hit(paddr_in, OFS_FIRST_SETUP_REGISTER)  | hit(paddr_in, OFS_PROBE)
                   | hit(paddr_in, OFS_NEXT_STN) | hit(paddr_in, OFS_DIAG)
                   | hit(paddr_in, OFS_XSTAT)   | hit(paddr_in, OFS_CMD);
    assign pready_out  = 1'b1;
    assign pslverr_out = acc & ~mapped;
    assign diag_rd = rd_en & hit(paddr_in, OFS_DIAG);
    assign stn_wr  = wr_en & hit(paddr_in, OFS_STATION);
    assign cmd_wr  = wr_en & hit(paddr_in, OFS_CMD);

    // Core gating
    assign core_run  = (station_q != STATION_RST);
    assign joined    = core_run & join_allow_bit_q;
    assign join_evt  = joined & ~join_prev_q;
    assign timer_evt = joined & net_ev_in.rx_timer_expired;
    assign core_ctl_out.core_run    = core_run;
    assign core_ctl_out.may_join    = joined;
    assign core_ctl_out.rebuild_req = join_evt | timer_evt;

    // An answer refers to the most recently seen foreign token
    assign answered_dest_ok = core_run & net_ev_in.token_answered & last_valid_q;
    // Before joining nobody else may answer our number; after, we answer it ourselves
    assign clash_set = answered_dest_ok & ~joined & (last_dest_q == station_q);
    assign probe_set = answered_dest_ok & probe_armed_q & (last_dest_q == probe_q);

    // Refusal threshold select
    assign refuse_max = setup_q[SU_SHORT_BIT] ? REFUSE_SHORT_MAX : REFUSE_LONG_MAX;
    assign refuse_max_hit = net_ev_in.refusal & (refuse_cnt_q == refuse_max);

    // Clash window length; long unless both select bits are one
    assign win_limit = (setup_q[SU_SEL1_BIT] & setup_q[SU_SEL2_BIT])
                     ? WIN_CNT_W'(CLASH_WIN_CYCLES) : WIN_CNT_W'(CLASH_LONG_CYCLES);

    // Station number; a write restarts the clash window
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            station_q <= STATION_RST;
        end else if (stn_wr) begin
            station_q <= pwdata_in[STN_W-1:0];
        end
    end

    // Configuration and setup
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            join_allow_bit_q <= 1'b0;
            setup_q          <= SETUP_RST;
            join_prev_q      <= 1'b0;
        end else begin
            join_prev_q <= joined;
            if (wr_en && hit(paddr_in, OFS_CONFIG)) begin
                join_allow_bit_q <= pwdata_in[CFG_JOIN_BIT];
            end
            if (wr_en && hit(paddr_in, OFS_FIRST_SETUP_REGISTER)) begin
                setup_q <= pwdata_in[SU_W-1:0];
            end
        end
    end

    // Probe value; any write arms the watch, even once joined
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            probe_q       <= STATION_RST;
            probe_armed_q <= 1'b0;
        end else if (wr_en && hit(paddr_in, OFS_PROBE)) begin
            probe_q       <= pwdata_in[STN_W-1:0];
            probe_armed_q <= 1'b1;
        end
    end

    // Last foreign token destination, for answer matching
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_dest_q  <= STATION_RST;
            last_valid_q <= 1'b0;
        end else if (net_ev_in.token_seen && !net_ev_in.token_own) begin
            last_dest_q  <= net_ev_in.token_dest;
            last_valid_q <= 1'b1;
        end
    end

    // Successor tracking
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            next_stn_q <= STATION_RST;
        end else if (net_ev_in.successor_valid) begin
            next_stn_q <= net_ev_in.successor_id;
        end
    end

    // Sticky diagnostic flags; a set in the clearing cycle wins
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            self_caused_ring_rebuild_q <= 1'b0;
            clash_detected_flag_q      <= 1'b0;
            line_activity_flag_q       <= 1'b0;
            pass_frame_seen_q          <= 1'b0;
            successor_changed_flag_q   <= 1'b0;
            probe_match_flag_q         <= 1'b0;
        end else begin
            self_caused_ring_rebuild_q <= (self_caused_ring_rebuild_q & ~diag_rd)
                                        | join_evt | timer_evt;
            clash_detected_flag_q      <= (clash_detected_flag_q & ~diag_rd)
                                        | clash_set;
            line_activity_flag_q       <= (line_activity_flag_q & ~diag_rd)
                                        | serial_receive_input_in;
            pass_frame_seen_q          <= (pass_frame_seen_q & ~diag_rd)
                                        | (net_ev_in.token_seen & ~net_ev_in.token_own);
            successor_changed_flag_q   <= (successor_changed_flag_q & ~diag_rd)
                                        | (net_ev_in.successor_valid
                                           & (net_ev_in.successor_id != next_stn_q));
            probe_match_flag_q         <= (probe_match_flag_q & ~diag_rd)
                                        | probe_set;
        end
    end

    // Clash window: reports when a full watch period has passed
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            win_cnt_q    <= '0;
            clash_done_q <= 1'b0;
        end else if (stn_wr) begin
            win_cnt_q    <= '0;
            clash_done_q <= 1'b0;
        end else if (core_run && !clash_done_q) begin
            if (win_cnt_q >= win_limit - WIN_CNT_W'(1)) begin
                clash_done_q <= 1'b1;
            end else begin
                win_cnt_q <= win_cnt_q + WIN_CNT_W'(1);
            end
        end
    end

    // Refusal counter wraps so the flag can fire again
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            refuse_cnt_q <= '0;
        end else if (net_ev_in.buffer_ok) begin
            refuse_cnt_q <= '0;
        end else if (refuse_max_hit) begin
            refuse_cnt_q <= '0;
        end else if (net_ev_in.refusal) begin
            refuse_cnt_q <= refuse_cnt_q + REFUSE_CNT_W'(1);
        end
    end

    // Refusal limit flag; cleared only by the flag-clear command
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            refusal_limit_flag_q <= 1'b0;
        end else begin
            refusal_limit_flag_q <= (refusal_limit_flag_q
                                     & ~(cmd_wr & pwdata_in[CMD_CLEAR_BIT]))
                                  | refuse_max_hit;
        end
    end

    // Sender release: disable is honoured at the next token we receive
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sender_free_flag_q <= 1'b1;
            disable_pend_q     <= 1'b0;
        end else if (cmd_wr && pwdata_in[CMD_DISABLE_BIT]) begin
            sender_free_flag_q <= 1'b0;
            disable_pend_q     <= 1'b1;
        end else if (disable_pend_q && net_ev_in.token_for_us) begin
            sender_free_flag_q <= 1'b1;
            disable_pend_q     <= 1'b0;
        end
    end

    // Start-up buffer writes after a non-zero station number
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ram_st_q <= NJD_RAM_IDLE;
        end else begin
            unique case (ram_st_q)
                NJD_RAM_IDLE: begin
                    if (stn_wr && (pwdata_in[STN_W-1:0] != STATION_RST)) begin
                        ram_st_q <= NJD_RAM_MARK;
                    end
                end
                NJD_RAM_MARK: begin
                    ram_st_q <= NJD_RAM_STN;
                end
                NJD_RAM_STN: begin
                    ram_st_q <= NJD_RAM_IDLE;
                end
                default: begin
                    ram_st_q <= NJD_RAM_IDLE;
                end
            endcase
        end
    end

    // Buffer write port decode from state
    always_comb begin
        ram_wr_out.we   = 1'b0;
        ram_wr_out.addr = RAM_ADDR_MARK;
        ram_wr_out.data = RAM_MARK_DATA;
        if (ram_st_q == NJD_RAM_MARK) begin
            ram_wr_out.we = 1'b1;
        end else if (ram_st_q == NJD_RAM_STN) begin
            ram_wr_out.we   = 1'b1;
            ram_wr_out.addr = RAM_ADDR_STN;
            ram_wr_out.data = station_q;
        end
    end

    // Interrupt follows the refusal flag level
    assign refusal_irq_out = refusal_limit_flag_q;

    // Read mux; unmapped and write cycles return zero
    always_comb begin
        prdata_out = '0;
        if (rd_en) begin
            if (hit(paddr_in, OFS_STATION)) begin
                prdata_out[STN_W-1:0] = station_q;
            end else if (hit(paddr_in, OFS_CONFIG)) begin
                prdata_out[CFG_JOIN_BIT] = join_allow_bit_q;
            end else if (hit(paddr_in, OFS_FIRST_SETUP_REGISTER)) begin
                prdata_out[SU_W-1:0] = setup_q;
            end else if (hit(paddr_in, OFS_PROBE)) begin
                prdata_out[STN_W-1:0] = probe_q;
            end else if (hit(paddr_in, OFS_NEXT_STN)) begin
                prdata_out[STN_W-1:0] = next_stn_q;
            end else if (hit(paddr_in, OFS_DIAG)) begin
                prdata_out[DG_SELF_BIT]  = self_caused_ring_rebuild_q;
                prdata_out[DG_CLASH_BIT] = clash_detected_flag_q;
                prdata_out[DG_LINE_BIT]  = line_activity_flag_q;
                prdata_out[DG_PASS_BIT]  = pass_frame_seen_q;
                prdata_out[DG_SUCC_BIT]  = successor_changed_flag_q;
                prdata_out[DG_PROBE_BIT] = probe_match_flag_q;
                prdata_out[DG_DONE_BIT]  = clash_done_q;
            end else if (hit(paddr_in, OFS_XSTAT)) begin
                prdata_out[XS_FREE_BIT]   = sender_free_flag_q;
                prdata_out[XS_REFUSE_BIT] = refusal_limit_flag_q;
            end
        end
    end

endmodule

/* testbench/njd_chk_asserts.sv */
// Port checker for the join and diagnostics block
`timescale 1ns/10ps
module njd_chk
    import njd_pkg::*;
#(
    parameter int unsigned CLASH_WIN_CYCLES  = 20,
    parameter int unsigned CLASH_LONG_CYCLES = 40
) (
    // Clock, reset and bus
    input wire logic                   clk_in,
    input wire logic                   rst_n_in,
    input wire logic                   psel_in,
    input wire logic                   penable_in,
    input wire logic                   pwrite_in,
    input wire logic [ADDR_W-1:0]      paddr_in,
    input wire logic [DATA_W-1:0]      pwdata_in,
    // Network and core side
    input wire njd_pkg::njd_net_ev_t   net_ev_in,
    input wire njd_pkg::njd_core_ctl_t core_ctl_out,
    input wire njd_pkg::njd_ram_wr_t   ram_wr_out,
    input wire logic                   refusal_irq_out
);
    // Bus writes taken at this edge
    wire bus_wr = psel_in && penable_in && pwrite_in;
    wire stn_wr = bus_wr && paddr_in == OFS_STATION;
    wire clr_wr = bus_wr && paddr_in == OFS_CMD && pwdata_in[CMD_CLEAR_BIT];
    wire run    = core_ctl_out.core_run;
    wire join_q = core_ctl_out.may_join;
    wire rbld   = core_ctl_out.rebuild_req;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_idle_no_rebuild: assert property (!run |-> !rbld)
        else $error("rebuild while core idle");
    a_zero_stays_idle: assert property (
        stn_wr && pwdata_in[7:0] == 8'h00 |=> !run && !ram_wr_out.we)
        else $error("zero station woke core");
    a_join_needs_run: assert property (join_q |-> run)
        else $error("join without station");
    a_join_rebuild: assert property ($rose(join_q) |-> ##[0:1] rbld)
        else $error("no rebuild on join");
    a_timer_rebuild: assert property (
        net_ev_in.rx_timer_expired && join_q |-> ##[0:1] rbld)
        else $error("no rebuild on timer expiry");
    a_ram_mark: assert property (
        stn_wr && pwdata_in[7:0] != 8'h00 |=> ram_wr_out.we
        && ram_wr_out.addr == RAM_ADDR_MARK && ram_wr_out.data == RAM_MARK_DATA)
        else $error("mark write missing");
    a_ram_number: assert property (
        ram_wr_out.we && ram_wr_out.addr == RAM_ADDR_MARK |=> ram_wr_out.we
        && ram_wr_out.addr == RAM_ADDR_STN && ram_wr_out.data == $past(pwdata_in[7:0], 2))
        else $error("number write missing");
    a_irq_held: assert property ($fell(refusal_irq_out) |-> $past(clr_wr))
        else $error("refusal flag dropped alone");
    a_irq_cause: assert property ($rose(refusal_irq_out) |-> $past(net_ev_in.refusal))
        else $error("refusal flag without refusal");

    // Main scenarios reached
    c_join: cover property ($rose(join_q));
    c_irq: cover property ($rose(refusal_irq_out));
    c_ram: cover property (ram_wr_out.we);
endmodule

bind njd_top njd_chk #(
    .CLASH_WIN_CYCLES(CLASH_WIN_CYCLES), .CLASH_LONG_CYCLES(CLASH_LONG_CYCLES)
) u_chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .net_ev_in(net_ev_in), .core_ctl_out(core_ctl_out), .ram_wr_out(ram_wr_out),
    .refusal_irq_out(refusal_irq_out)
);

/* testbench/njd_net_partner.sv */
// Model of the other nodes on the shared network
`timescale 1ns/10ps
module njd_net_partner
    import njd_pkg::*;
(
    input  wire logic            clk_in,
    output njd_pkg::njd_net_ev_t net_ev_out,
    output logic                 rxd_out
);
    initial begin
        net_ev_out = '0;
        rxd_out    = 1'b0;
    end

    // One event: pulse, then answer cycle, then idle; released ids show inverse
    task automatic ev(input logic [2:0] kind, input logic [7:0] v, input logic ans);
        njd_net_ev_t e;
        njd_net_ev_t i;
        i = '0;
        i.token_dest   = ~v;
        i.successor_id = ~v;
        e = i;
        case (kind)
            3'h0, 3'h1: begin
                e.token_seen = 1'b1;
                e.token_own  = kind[0];
                e.token_dest = v;
            end
            3'h2: e.rx_timer_expired = 1'b1;
            3'h3: begin
                e.successor_valid = 1'b1;
                e.successor_id    = v;
            end
            3'h4: e.refusal = 1'b1;
            3'h5: e.token_for_us = 1'b1;
            default: e.buffer_ok = 1'b1;
        endcase
        @(posedge clk_in);
        net_ev_out <= e;
        rxd_out    <= (kind == 3'h0);
        @(posedge clk_in);
        i.token_answered = ans;
        net_ev_out <= i;
        rxd_out    <= 1'b0;
        @(posedge clk_in);
        i.token_answered = 1'b0;
        net_ev_out <= i;
    endtask
endmodule

/* testbench/njd_top_tb_top.sv */
// Testbench: start-up gating, sticky diagnostics and refusal counting
`timescale 1ns/10ps
module njd_top_tb_top;
    import njd_pkg::*;
    logic          clk_in     = 1'b0;
    logic          rst_n_in   = 1'b0;
    logic          psel_in    = 1'b0;
    logic          penable_in = 1'b0;
    logic          pwrite_in  = 1'b0;
    logic [7:0]    paddr_in   = 8'h00;
    logic [31:0]   pwdata_in  = 32'h0;
    logic [31:0]   prdata_out;
    logic          pready_out;
    logic          pslverr_out;
    logic          rxd;
    njd_net_ev_t   net_ev;
    njd_core_ctl_t core_ctl;
    njd_ram_wr_t   ram_wr;
    logic          irq;
    int            n_errors   = 0;
    int            checks     = 0;

    always #5 clk_in = ~clk_in;

    njd_top #(.CLASH_WIN_CYCLES(20), .CLASH_LONG_CYCLES(40)) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .serial_receive_input_in(rxd), .net_ev_in(net_ev), .core_ctl_out(core_ctl),
        .ram_wr_out(ram_wr), .refusal_irq_out(irq));
    njd_net_partner u_net (.clk_in(clk_in), .net_ev_out(net_ev), .rxd_out(rxd));

    task automatic stop_test();
        $display("Counts: %0d checks, %0d errors", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Setup, access until pready, then release
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_in);
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            stop_test();
        end
        r = prdata_out;
        e = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        cmp(r, exp);
        cmp({31'h0, e}, {31'h0, a > OFS_CMD});
    endtask

    task automatic t_start();
        cmp({29'h0, core_ctl}, 32'h0);
        wr(OFS_STATION, 32'h0);
        u_net.ev(3'h2, 8'h00, 1'b0);
        cmp({28'h0, ram_wr.we, core_ctl}, 32'h0);
        rd(OFS_XSTAT, 32'h1);
        rd(OFS_DIAG, 32'h0);
        rd(8'h40, 32'h0);
        $display("test start done");
    endtask

    // Station write, buffer writes, clash window at one select setting
    task automatic t_window(input logic [31:0] su, input int t);
        wr(OFS_FIRST_SETUP_REGISTER, su);
        wr(OFS_STATION, 32'h05);
        #1;
        cmp({12'h0, ram_wr}, {12'h0, 1'b1, RAM_ADDR_MARK, RAM_MARK_DATA});
        @(posedge clk_in);
        #1;
        cmp({12'h0, ram_wr}, {12'h0, 1'b1, RAM_ADDR_STN, 8'h05});
        cmp({29'h0, core_ctl}, 32'h4);
        repeat (t) @(posedge clk_in);
        rd(OFS_DIAG, 32'h0);
        repeat (t) @(posedge clk_in);
        rd(OFS_DIAG, 32'h2);
        $display("test window done");
    endtask

    task automatic t_clash();
        u_net.ev(3'h0, 8'h05, 1'b1);
        repeat (4) @(posedge clk_in);
        rd(OFS_DIAG, 32'h72);
        rd(OFS_DIAG, 32'h02);
        u_net.ev(3'h0, 8'h05, 1'b0);
        rd(OFS_DIAG, 32'h32);
        $display("test clash done");
    endtask

    task automatic t_join();
        wr(OFS_CONFIG, 32'h20);
        #1;
        cmp({29'h0, core_ctl}, 32'h7);
        rd(OFS_DIAG, 32'h82);
        u_net.ev(3'h2, 8'h00, 1'b0);
        rd(OFS_DIAG, 32'h82);
        rd(OFS_DIAG, 32'h02);
        $display("test join done");
    endtask

    task automatic t_probe();
        wr(OFS_PROBE, 32'h09);
        u_net.ev(3'h0, 8'h09, 1'b1);
        rd(OFS_DIAG, 32'h36);
        u_net.ev(3'h1, 8'h09, 1'b0);
        rd(OFS_DIAG, 32'h02);
        u_net.ev(3'h3, 8'h22, 1'b0);
        rd(OFS_NEXT_STN, 32'h22);
        rd(OFS_DIAG, 32'h0a);
        $display("test probe done");
    endtask

    task automatic t_refuse(input logic [31:0] su, input int lim);
        wr(OFS_FIRST_SETUP_REGISTER, su);
        u_net.ev(3'h6, 8'h00, 1'b0);
        repeat (lim - 1) u_net.ev(3'h4, 8'h00, 1'b0);
        rd(OFS_XSTAT, 32'h1);
        u_net.ev(3'h4, 8'h00, 1'b0);
        rd(OFS_XSTAT, 32'h3);
        cmp({31'h0, irq}, 32'h1);
        wr(OFS_CMD, 32'h2);
        rd(OFS_XSTAT, 32'h1);
        repeat (lim) u_net.ev(3'h4, 8'h00, 1'b0);
        rd(OFS_XSTAT, 32'h3);
        wr(OFS_CMD, 32'h3);
        rd(OFS_XSTAT, 32'h0);
        u_net.ev(3'h5, 8'h00, 1'b0);
        rd(OFS_XSTAT, 32'h1);
        $display("test refusal done");
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_start();
        t_window(32'h2, 25);
        t_window(32'h6, 12);
        t_clash();
        t_join();
        t_probe();
        t_refuse(32'h1, 4);
        t_refuse(32'h0, 128);
        stop_test();
    end
endmodule
